/* File: pin_reset_filter.sv */
// shared pin reset filter, direct or de-bounced
`timescale 1ns/1ps
module pin_reset_filter #(
    parameter int DEB_CYC = rst_pkg::DEBOUNCE_CYC
) (
    input wire logic               clock_i,
    input wire logic               sys_rst_i,
    input wire logic               pin_low_i,
    input wire rst_pkg::pin_mode_e mode_i,
    output logic                   req_o
);
    localparam int CW = $clog2(DEB_CYC + 1);
    if (DEB_CYC < 1) begin : g_bad
        $error("pin_reset_filter: DEB_CYC must be at least 1");
    end
    logic [CW-1:0] cnt_q, cnt_d;
    logic          req_d;

    always_comb begin
        cnt_d = '0;
        req_d = 1'b0;
        unique case (mode_i)
            rst_pkg::PIN_DIRECT: req_d = pin_low_i;
            rst_pkg::PIN_DEBOUNCE: begin
                if (pin_low_i && cnt_q != CW'(DEB_CYC)) begin
                    cnt_d = cnt_q + CW'(1);
                end else if (pin_low_i) begin
                    cnt_d = cnt_q;
                end
                req_d = pin_low_i && cnt_q == CW'(DEB_CYC);
            end
            default: req_d = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
            req_o <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            req_o <= req_d;
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    direct_reset_a: assert property (
        mode_i == rst_pkg::PIN_DIRECT && pin_low_i |=> req_o)
        else $error("direct pin low gave no reset");
    debounce_len_a: assert property ($rose(req_o)
        && $past(mode_i) == rst_pkg::PIN_DEBOUNCE
        |-> $past(cnt_q) == CW'(DEB_CYC))
        else $error("de-bounced reset before full low time");
    gpio_quiet_a: assert property (
        mode_i == rst_pkg::PIN_GPIO |=> !req_o)
        else $error("reset from pin in gpio mode");
endmodule // pin_reset_filter

/* File: reset_poweron_controller.sv */
// reset and power-on controller with APB register slave
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module reset_poweron_controller #(
    parameter int PWR_CYC  = rst_pkg::PWR_STAB_CYC,
    parameter int DEB_CYC  = rst_pkg::DEBOUNCE_CYC,
    parameter int ILRC_CYC = rst_pkg::ILRC_CYC,
    parameter int HOSC_CYC = rst_pkg::HOSC_CYC
) (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        low_voltage_detector_i,
    input  wire logic        shared_reset_gpio_pin_i,
    input  wire logic        cpu_idle_i,
    input  wire logic        cpu_stop_i,
    output logic             core_rst_o,
    output logic             clk_src_load_o,
    output logic             hosc_run_o,
    output logic             gpio_mode_o,
    output logic [15:0]      reset_vector_o
);
    localparam int PW = $clog2(PWR_CYC);
    localparam int IW = $clog2(ILRC_CYC);
    if (PWR_CYC < 2 || ILRC_CYC < 2 || HOSC_CYC < 1
        || HOSC_CYC > PWR_CYC) begin : g_bad
        $error("reset_poweron_controller: bad timing parameters");
    end

    ////////////////////////////////////////////////////////////////////
    // input synchronisers and low-speed tick
    logic          lvd_s1_q, lvd_s2_q, pin_s1_q, pin_s2_q;
    logic [IW-1:0] ilrc_q, ilrc_d;
    logic          ilrc_tick_q, ilrc_tick_d;

    always_comb begin
        ilrc_tick_d = (ilrc_q == IW'(ILRC_CYC - 1));
        ilrc_d      = ilrc_tick_d ? '0 : ilrc_q + IW'(1);
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            lvd_s1_q    <= 1'b0;
            lvd_s2_q    <= 1'b0;
            pin_s1_q    <= 1'b1;
            pin_s2_q    <= 1'b1;
            ilrc_q      <= '0;
            ilrc_tick_q <= 1'b0;
        end else begin
            lvd_s1_q    <= low_voltage_detector_i;
            lvd_s2_q    <= lvd_s1_q;
            pin_s1_q    <= shared_reset_gpio_pin_i;
            pin_s2_q    <= pin_s1_q;
            ilrc_q      <= ilrc_d;
            ilrc_tick_q <= ilrc_tick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reset sources
    wdt_link_if wl ();
    logic [6:0] opt_q, opt_d;
    logic       pin_req, kick, sw_fire, lvd_hit, hard_hit;
    logic       core_rst_q, core_rst_d;

    watchdog_timer u_wdt (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .wl        (wl.wdog)
    );

    pin_reset_filter #(.DEB_CYC(DEB_CYC)) u_pin (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .pin_low_i (!pin_s2_q),
        .mode_i    (rst_pkg::pin_mode_e'(opt_q[5:4])),
        .req_o     (pin_req)
    );

    assign wl.tick    = ilrc_tick_q;
    assign wl.kick    = kick;
    assign wl.restart = core_rst_q;
    assign wl.idle    = cpu_idle_i;
    assign wl.stop    = cpu_stop_i;
    assign wl.mode    = rst_pkg::wdt_mode_e'(opt_q[1:0]);
    assign wl.psc_sel = opt_q[3:2];
    assign lvd_hit    = opt_q[rst_pkg::OPT_LVD_BIT] && lvd_s2_q;
    assign hard_hit   = lvd_hit || wl.bite || pin_req;

    ////////////////////////////////////////////////////////////////////
    // APB slave, one wait state
    logic        acc, done, wr, hit;
    logic        pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic        armed_q, armed_d, sw_flag_q;
    logic [2:0]  cause_q;

    always_comb begin
        acc       = psel_i && penable_i;
        done      = acc && pready_q;
        wr        = done && pwrite_i;
        hit       = paddr_i == rst_pkg::CAUSE_OFS
                 || paddr_i == rst_pkg::SOFTWARE_RESET_CONTROL_OFS
                 || paddr_i == rst_pkg::KEY_OFS
                 || paddr_i == rst_pkg::OPT_OFS;
        pready_d  = acc && !pready_q;
        pslverr_d = pready_d && !hit;
        prdata_d  = prdata_q;
        if (pready_d && !pwrite_i) begin
            prdata_d = '0;
            unique case (paddr_i)
                rst_pkg::CAUSE_OFS:
                    prdata_d[7:rst_pkg::CAUSE_LSB] = cause_q;
                rst_pkg::SOFTWARE_RESET_CONTROL_OFS:
                    prdata_d[rst_pkg::SOFTWARE_RESET_CONTROL_REQ_BIT] = sw_flag_q;
                rst_pkg::OPT_OFS: prdata_d[6:0] = opt_q;
                default: prdata_d = '0;
            endcase
        end
        opt_d   = opt_q;
        armed_d = armed_q;
        kick    = 1'b0;
        sw_fire = 1'b0;
        if (wr) begin
            armed_d = 1'b0;
            unique case (paddr_i)
                rst_pkg::OPT_OFS: opt_d = pwdata_i[6:0];
                rst_pkg::KEY_OFS:
                    kick = pwdata_i[7:0] == rst_pkg::WDT_KEY;
                rst_pkg::SOFTWARE_RESET_CONTROL_OFS: begin
                    sw_fire = pwdata_i[rst_pkg::SOFTWARE_RESET_CONTROL_REQ_BIT] && armed_q;
                    armed_d = pwdata_i[rst_pkg::SOFTWARE_RESET_CONTROL_REQ_BIT] && !armed_q;
                end
                default: armed_d = 1'b0;
            endcase
        end
        if (core_rst_q) begin
            armed_d = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
            opt_q     <= rst_pkg::OPT_RESET;
            armed_q   <= 1'b0;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
            opt_q     <= opt_d;
            armed_q   <= armed_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power-on sequencer and cause flags
    rst_pkg::seq_state_e state_q, state_d;
    logic [PW-1:0] cnt_q, cnt_d;
    logic [2:0]    settle_q, settle_d, cause_d;
    logic          sw_flag_d, load_q, load_d, hosc_q, hosc_d, gpio_q;
    logic [15:0]   vector_q;

    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        settle_d  = settle_q;
        load_d    = 1'b0;
        cause_d   = cause_q;
        sw_flag_d = sw_flag_q;
        unique case (state_q)
            rst_pkg::ST_RUN: begin
                if (hard_hit) begin
                    state_d   = rst_pkg::ST_HOLD;
                    cause_d   = '0;
                    sw_flag_d = 1'b0;
                end else if (sw_fire) begin
                    state_d   = rst_pkg::ST_SW_RST;
                    cause_d   = '0;
                    sw_flag_d = 1'b1;
                end
            end
            rst_pkg::ST_SW_RST: state_d = rst_pkg::ST_RUN;
            rst_pkg::ST_HOLD: begin
                cnt_d = '0;
                if (!lvd_hit && !pin_req) begin
                    state_d = rst_pkg::ST_PWR_STAB;
                end
            end
            rst_pkg::ST_PWR_STAB: begin
                cnt_d = cnt_q + PW'(1);
                if (cnt_q == PW'(PWR_CYC - 1)) begin
                    state_d = rst_pkg::ST_CLK_HOSC;
                    cnt_d   = '0;
                    load_d  = 1'b1;
                end
            end
            rst_pkg::ST_CLK_HOSC: begin
                cnt_d = cnt_q + PW'(1);
                if (cnt_q == PW'(HOSC_CYC - 1)) begin
                    state_d  = rst_pkg::ST_CLK_ILRC;
                    settle_d = '0;
                end
            end
            rst_pkg::ST_CLK_ILRC: begin
                if (ilrc_tick_q) begin
                    settle_d = settle_q + 3'h1;
                    // first tick only opens the window: full periods follow
                    if (settle_q == 3'(rst_pkg::ILRC_SETTLE)) begin
                        state_d = rst_pkg::ST_RUN;
                    end
                end
            end
            default: state_d = rst_pkg::ST_HOLD;
        endcase
        if (state_q != rst_pkg::ST_RUN && state_q != rst_pkg::ST_SW_RST
            && (lvd_hit || pin_req)) begin
            state_d = rst_pkg::ST_HOLD;
        end
        if (state_q != rst_pkg::ST_RUN || hard_hit) begin
            cause_d = cause_d | {lvd_hit, wl.bite, pin_req};
        end
        core_rst_d = state_d != rst_pkg::ST_RUN;
        hosc_d     = state_d != rst_pkg::ST_HOLD
                  && state_d != rst_pkg::ST_PWR_STAB;
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_q    <= rst_pkg::ST_HOLD;
            cnt_q      <= '0;
            settle_q   <= '0;
            cause_q    <= '0;
            sw_flag_q  <= 1'b0;
            core_rst_q <= 1'b1;
            load_q     <= 1'b0;
            hosc_q     <= 1'b0;
            gpio_q     <= 1'b0;
            vector_q   <= rst_pkg::RESET_VECTOR;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            settle_q   <= settle_d;
            cause_q    <= cause_d;
            sw_flag_q  <= sw_flag_d;
            core_rst_q <= core_rst_d;
            load_q     <= load_d;
            hosc_q     <= hosc_d;
            gpio_q     <= opt_d[5:4] >= 2'(rst_pkg::PIN_GPIO);
            vector_q   <= rst_pkg::RESET_VECTOR;
        end
    end

    assign prdata_o       = prdata_q;
    assign pready_o       = pready_q;
    assign pslverr_o      = pslverr_q;
    assign core_rst_o     = core_rst_q;
    assign clk_src_load_o = load_q;
    assign hosc_run_o     = hosc_q;
    assign gpio_mode_o    = gpio_q;
    assign reset_vector_o = vector_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_pwr_done;
        state_q == rst_pkg::ST_PWR_STAB && cnt_q == PW'(PWR_CYC - 1)
        && !lvd_hit && !pin_req;
    endsequence
    sequence s_clk_load;
        state_q == rst_pkg::ST_CLK_HOSC && clk_src_load_o && hosc_run_o;
    endsequence
    sequence s_sw_pulse;
        state_q == rst_pkg::ST_SW_RST && core_rst_o ##1
        state_q == rst_pkg::ST_RUN && !core_rst_o;
    endsequence

    pwr_then_load_a: assert property (s_pwr_done |=> s_clk_load)
        else $error("clock source not loaded after power wait");
    pwr_hold_a: assert property (state_q == rst_pkg::ST_PWR_STAB
        && cnt_q != PW'(PWR_CYC - 1) && !lvd_hit && !pin_req
        |=> state_q == rst_pkg::ST_PWR_STAB)
        else $error("power wait left early");
    clk_settle_a: assert property (state_q == rst_pkg::ST_CLK_ILRC
        && state_d == rst_pkg::ST_RUN
        |-> ilrc_tick_q && settle_q == 3'(rst_pkg::ILRC_SETTLE))
        else $error("core released before settle count");
    lvd_reset_a: assert property (state_q == rst_pkg::ST_RUN && lvd_hit
        |=> state_q == rst_pkg::ST_HOLD && core_rst_o && cause_q[2])
        else $error("low voltage gave no reset");
    sw_twice_a: assert property (state_q == rst_pkg::ST_RUN
        && sw_fire && !hard_hit |=> s_sw_pulse)
        else $error("software reset sequence wrong");
    sw_single_a: assert property (state_q == rst_pkg::ST_RUN && wr
        && paddr_i == rst_pkg::SOFTWARE_RESET_CONTROL_OFS && !armed_q && !hard_hit
        && pwdata_i[rst_pkg::SOFTWARE_RESET_CONTROL_REQ_BIT]
        |=> state_q == rst_pkg::ST_RUN && armed_q)
        else $error("single write caused software reset");
    sw_flag_a: assert property (state_q == rst_pkg::ST_SW_RST
        |=> sw_flag_q && cause_q == '0)
        else $error("software cause not recorded");
    cause_low_a: assert property (done && !pwrite_i
        && paddr_i == rst_pkg::CAUSE_OFS |-> prdata_o[4:0] == '0)
        else $error("cause low bits not zero");
    vector_a: assert property ($fell(core_rst_o)
        |-> state_q == rst_pkg::ST_RUN && reset_vector_o == '0)
        else $error("release without run state");
endmodule // reset_poweron_controller

/* File: reset_poweron_controller_bench.sv */
// self-checking bench of the reset and power-on controller
`timescale 1ns/1ps
module reset_poweron_controller_bench;
    localparam int PWR   = 50;
    localparam int DEB   = 20;
    localparam int ILRC  = 4;
    localparam int HOSC  = 10;
    localparam int SEQ   = PWR + HOSC + 5 * ILRC;
    localparam int BITE  = 256 * 4 * ILRC;
    localparam int LIMIT = 50000;
    logic        clock_i, sys_rst_i, psel, penable, pwrite;
    logic        low_voltage_detector, pin, idle, stop;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata_o;
    logic        pready_o, pslverr_o, core_rst_o, clk_src_load_o;
    logic        hosc_run_o, gpio_mode_o;
    logic [15:0] reset_vector_o;
    logic [31:0] r;
    logic        e;
    int          error_cnt, compares, cyc, loads;

    reset_poweron_controller #(
        .PWR_CYC(PWR), .DEB_CYC(DEB), .ILRC_CYC(ILRC), .HOSC_CYC(HOSC)
    ) i_dut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .low_voltage_detector_i(low_voltage_detector),
        .shared_reset_gpio_pin_i(pin), .cpu_idle_i(idle),
        .cpu_stop_i(stop), .core_rst_o(core_rst_o),
        .clk_src_load_o(clk_src_load_o), .hosc_run_o(hosc_run_o),
        .gpio_mode_o(gpio_mode_o), .reset_vector_o(reset_vector_o)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        cyc++;
        if (clk_src_load_o === 1'b1) loads++;
        if (cyc == LIMIT) begin
            error_cnt++;
            $display("MISMATCH %0t run too long", $time);
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        r = prdata_o;
        e = pslverr_o;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock_i);
        if (n >= 20) chk(32'h0, 32'h1, "no apb answer");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(r, x, "read data");
    endtask

    // waits up to lim cycles for core reset, then checks its presence
    task automatic wait_rst(input int lim, input logic x);
        int n;
        n = 0;
        while (core_rst_o !== 1'b1 && n < lim) begin
            @(posedge clock_i);
            n++;
        end
        chk({31'h0, core_rst_o}, {31'h0, x}, "core reset presence");
    endtask

    // waits for core release; hard resets run the whole sequence
    task automatic wait_run(input logic hard);
        int n;
        int l0;
        n = 0;
        l0 = loads;
        while (core_rst_o !== 1'b0 && n < 2000) begin
            @(posedge clock_i);
            n++;
        end
        chk(32'(loads - l0), {31'h0, hard}, "clock source load count");
        if (hard) chk({31'h0, n >= SEQ}, 32'h1, "sequence too short");
        if (hard) chk({31'h0, hosc_run_o}, 32'h1, "fast osc not run");
        chk({31'h0, core_rst_o}, 32'h0, "core not released");
    endtask

    task automatic close_out();
        if (error_cnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, idle, stop} = '0;
        {low_voltage_detector, paddr, pwdata} = '0;
        pin = 1'b1;
        sys_rst_i = 1'b1;
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        wait_run(1'b1);
        chk({16'h0, reset_vector_o}, 32'h0, "reset vector");
        rd(rst_pkg::CAUSE_OFS, 32'h0);
        rd(rst_pkg::OPT_OFS, 32'h60);
        rd(rst_pkg::SOFTWARE_RESET_CONTROL_OFS, 32'h0);
        rd(rst_pkg::KEY_OFS, 32'h0);
        xfer(1'b0, 8'h10, 32'h0);
        chk({31'h0, e}, 32'h1, "unmapped not refused");
        wr(rst_pkg::OPT_OFS, 32'h62);
        // software reset: disarm, then two writes in a row
        wr(rst_pkg::SOFTWARE_RESET_CONTROL_OFS, 32'h1);
        wr(rst_pkg::SOFTWARE_RESET_CONTROL_OFS, 32'h0);
        wr(rst_pkg::SOFTWARE_RESET_CONTROL_OFS, 32'h1);
        wait_rst(20, 1'b0);
        wr(rst_pkg::SOFTWARE_RESET_CONTROL_OFS, 32'h1);
        wait_rst(3, 1'b1);
        @(posedge clock_i);
        chk({31'h0, core_rst_o}, 32'h0, "soft pulse long");
        wait_run(1'b0);
        rd(rst_pkg::SOFTWARE_RESET_CONTROL_OFS, 32'h1);
        // watchdog in always mode while stopped, kicked then starved
        wr(rst_pkg::OPT_OFS, 32'h60);
        stop <= 1'b1;
        wr(rst_pkg::KEY_OFS, 32'h5a);
        repeat (3) begin
            wait_rst(BITE - 600, 1'b0);
            wr(rst_pkg::KEY_OFS, 32'h5a);
        end
        wait_rst(2000, 1'b0);
        wr(rst_pkg::KEY_OFS, 32'h33);
        wait_rst(BITE - 2400, 1'b0);
        wait_rst(500, 1'b1);
        stop <= 1'b0;
        wait_run(1'b1);
        rd(rst_pkg::CAUSE_OFS, 32'h40);
        rd(rst_pkg::SOFTWARE_RESET_CONTROL_OFS, 32'h0);
        // enable mode at prescale 8 halts in idle, counts in normal
        wr(rst_pkg::OPT_OFS, 32'h65);
        idle <= 1'b1;
        wr(rst_pkg::KEY_OFS, 32'h5a);
        wait_rst(6000, 1'b0);
        idle <= 1'b0;
        wait_rst(2 * BITE - 300, 1'b0);
        wait_rst(600, 1'b1);
        wait_run(1'b1);
        wr(rst_pkg::OPT_OFS, 32'h62);
        wait_rst(6000, 1'b0);
        // pin without de-bounce
        wr(rst_pkg::OPT_OFS, 32'h52);
        repeat (2) @(posedge clock_i);
        chk({31'h0, gpio_mode_o}, 32'h0, "pin mode");
        pin <= 1'b0;
        wait_rst(10, 1'b1);
        repeat (30) @(posedge clock_i);
        chk({31'h0, core_rst_o}, 32'h1, "pin reset dropped");
        pin <= 1'b1;
        wait_run(1'b1);
        rd(rst_pkg::CAUSE_OFS, 32'h20);
        // pin with de-bounce: short pulse, then long low
        wr(rst_pkg::OPT_OFS, 32'h42);
        pin <= 1'b0;
        repeat (DEB - 5) @(posedge clock_i);
        pin <= 1'b1;
        wait_rst(60, 1'b0);
        pin <= 1'b0;
        wait_rst(DEB, 1'b0);
        wait_rst(12, 1'b1);
        pin <= 1'b1;
        wait_run(1'b1);
        // pin as plain gpio
        wr(rst_pkg::OPT_OFS, 32'h62);
        repeat (2) @(posedge clock_i);
        chk({31'h0, gpio_mode_o}, 32'h1, "gpio mode");
        pin <= 1'b0;
        wait_rst(60, 1'b0);
        pin <= 1'b1;
        // low voltage, option off then on
        wr(rst_pkg::OPT_OFS, 32'h22);
        low_voltage_detector <= 1'b1;
        wait_rst(20, 1'b0);
        low_voltage_detector <= 1'b0;
        wr(rst_pkg::OPT_OFS, 32'h62);
        low_voltage_detector <= 1'b1;
        wait_rst(10, 1'b1);
        low_voltage_detector <= 1'b0;
        wait_run(1'b1);
        rd(rst_pkg::CAUSE_OFS, 32'h80);
        close_out();
    end
endmodule // reset_poweron_controller_bench

/* File: rst_pkg.sv */
// shared constants and types of the reset and power-on controller
package rst_pkg;
    // clock and timing
    localparam int CLK_MHZ      = 100;
    localparam int PWR_STAB_US  = 4600;
    localparam int PWR_STAB_CYC = PWR_STAB_US * CLK_MHZ;
    localparam int DEBOUNCE_MS  = 8;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ;
    localparam int ILRC_HZ      = 16000;
    localparam int ILRC_CYC     = CLK_MHZ * 1000000 / ILRC_HZ;
    localparam int HOSC_MHZ     = 32;
    localparam int HOSC_PERIODS = 2048;
    localparam int HOSC_CYC     = (HOSC_PERIODS * CLK_MHZ + HOSC_MHZ - 1)
                                  / HOSC_MHZ;
    localparam int ILRC_SETTLE  = 5;
    localparam int WDT_TICKS    = 256;
    localparam int WDT_PSC_MIN  = 4;
    localparam logic [7:0]  WDT_KEY      = 8'h5a;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    // register byte offsets
    localparam logic [7:0] CAUSE_OFS = 8'h00;
    localparam logic [7:0] SOFTWARE_RESET_CONTROL_OFS  = 8'h04;
    localparam logic [7:0] KEY_OFS   = 8'h08;
    localparam logic [7:0] OPT_OFS   = 8'h0c;
    // field positions
    localparam int SOFTWARE_RESET_CONTROL_REQ_BIT = 0;
    localparam int CAUSE_LSB    = 5;
    localparam int OPT_LVD_BIT  = 6;
    localparam logic [6:0] OPT_RESET = 7'h60;
    typedef enum logic [1:0] {WDT_ALWAYS, WDT_ENABLE, WDT_DISABLE} wdt_mode_e;
    typedef enum logic [1:0] {PIN_DEBOUNCE, PIN_DIRECT, PIN_GPIO} pin_mode_e;
    typedef enum logic [2:0] {
        ST_HOLD, ST_PWR_STAB, ST_CLK_HOSC, ST_CLK_ILRC, ST_SW_RST, ST_RUN
    } seq_state_e;
endpackage

/* File: watchdog_timer.sv */
// watchdog timer on low-speed ticks with prescaler
`timescale 1ns/1ps
module watchdog_timer (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    wdt_link_if.wdog wl
);
    logic [4:0] psc_q, psc_d, psc_top;
    logic [7:0] cnt_q, cnt_d;
    logic       bite_q, bite_d, run;

    always_comb begin
        psc_top = 5'((rst_pkg::WDT_PSC_MIN << wl.psc_sel) - 1);
        unique case (wl.mode)
            rst_pkg::WDT_ALWAYS: run = 1'b1;
            rst_pkg::WDT_ENABLE: run = !(wl.idle || wl.stop);
            default:             run = 1'b0;
        endcase
        psc_d  = psc_q;
        cnt_d  = cnt_q;
        bite_d = 1'b0;
        if (wl.restart || wl.kick) begin
            psc_d = '0;
            cnt_d = '0;
        end else if (run && wl.tick) begin
            if (psc_q == psc_top) begin
                psc_d  = '0;
                cnt_d  = cnt_q + 8'h01;
                bite_d = (cnt_q == 8'(rst_pkg::WDT_TICKS - 1));
            end else begin
                psc_d = psc_q + 5'h01;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            psc_q  <= '0;
            cnt_q  <= '0;
            bite_q <= 1'b0;
        end else begin
            psc_q  <= psc_d;
            cnt_q  <= cnt_d;
            bite_q <= bite_d;
        end
    end
    assign wl.bite = bite_q;

    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    kick_clears_a: assert property (wl.kick |=> cnt_q == '0 && !bite_q)
        else $error("watchdog count not cleared by key");
    bite_period_a: assert property (bite_q |-> cnt_q == '0
        && $past(cnt_q) == 8'(rst_pkg::WDT_TICKS - 1))
        else $error("watchdog bite at wrong count");
    halt_no_bite_a: assert property ($past(!run) |-> !bite_q)
        else $error("watchdog bit while halted");
endmodule // watchdog_timer

/* File: wdt_link_if.sv */
// link between sequencer and watchdog timer
`timescale 1ns/1ps
interface wdt_link_if;
    logic                  tick;
    logic                  kick;
    logic                  restart;
    logic                  idle;
    logic                  stop;
    logic                  bite;
    rst_pkg::wdt_mode_e    mode;
    logic [1:0]            psc_sel;
    modport ctrl (output tick, kick, restart, idle, stop, mode, psc_sel,
                  input bite);
    modport wdog (input tick, kick, restart, idle, stop, mode, psc_sel,
                  output bite);
endinterface
